/* pkg/acsf_cfg.svh */
// Purpose: Offsets, field positions and reset values of the accumulator block
// Assumes: Byte-wide registers in low bits of 32-bit Wishbone words
// Notes:   Definitions only
`ifndef ACSF_CFG_SVH
`define ACSF_CFG_SVH
`define ACSF_OFF_PSF      8'h86
`define ACSF_OFF_ACC      8'h80
`define ACSF_OFF_IRQ_STAT 8'h88
`define ACSF_OFF_IRQ_EN   8'h8C
`define ACSF_OFF_IRQ_CLR  8'h90
`define ACSF_BIT_RC_HI    7
`define ACSF_BIT_RC_LO    6
`define ACSF_BIT_LV_HIGH  5
`define ACSF_BIT_LV_MID   4
`define ACSF_BIT_C        2
`define ACSF_BIT_DC       1
`define ACSF_BIT_Z        0
`define ACSF_RC_WDT       2'h0
`define ACSF_RC_LVD       2'h2
`define ACSF_RC_PIN       2'h3
`define ACSF_ACC_RST      8'h00
`define ACSF_IRQ_W        3
`endif

/* pkg/acsf_pkg.sv */
// Purpose: Types of the accumulator and status flag block
// Assumes: Config header holds offsets and bits; op and state codes are set here
// Notes:   Operation codes are issued by the execution logic
package acsf_pkg;
    typedef enum logic [3:0] {
        ACSF_OP_NONE = 4'h0,
        ACSF_OP_ADD  = 4'h1,
        ACSF_OP_ADC  = 4'h2,
        ACSF_OP_SUB  = 4'h3,
        ACSF_OP_AND  = 4'h4,
        ACSF_OP_OR   = 4'h5,
        ACSF_OP_XOR  = 4'h6,
        ACSF_OP_RRC  = 4'h7,
        ACSF_OP_RLC  = 4'h8,
        ACSF_OP_CMP  = 4'h9,
        ACSF_OP_MOVA = 4'hA,
        ACSF_OP_PUSH = 4'hB,
        ACSF_OP_POP  = 4'hC,
        ACSF_OP_ZTST = 4'hD
    } acsf_op_type;

    typedef struct packed {
        acsf_op_type op;
        logic [7:0]  operand;
        logic        to_acc;
    } acsf_req_type;

    typedef struct packed {
        logic [7:0] result;
        logic       result_valid;
    } acsf_res_type;

    typedef enum logic [1:0] {
        ACSF_ST_IDLE = 2'b01,
        ACSF_ST_ACK  = 2'b10
    } acsf_bus_state_type;
endpackage

/* design/acsf_core.sv */
// Purpose: Accumulator, program status flags and push/pop save buffers
// Assumes: Execution logic gives one op per enabled cycle; reset cause
//          is held stable by the system reset logic at reset release
// Notes:   One-cycle Wishbone ack; unmapped reads return zero
// How it works
// RULE1: An 8-bit accumulator carries ALU operands and results.
// RULE2: Zero, carry and nibble carry of each operation land in the flags.
// RULE3: The accumulator is no data memory location; direct moves miss it.
// RULE4: Interrupt entry leaves accumulator and flags untouched.
// RULE5: Push copies accumulator and flags to buffers; pop restores both.
// RULE6: Status at 086H: cause, two supply flags, spare bit, C, DC, Z.
// RULE7: Cause in bits 7:6: 00 watchdog, 01 reserved, 10 low supply, 11 pin.
// RULE8: Bit 5 is 1 while supply is at or below 3.6 V, high option only.
// RULE9: Bit 4 is 1 while supply is at or below 2.4 V, mid option only.
// RULE10: Carry: add carry, no borrow, rotated-out one, compare not negative.
// RULE11: Decimal carry sets on low nibble carry or no nibble borrow.
// RULE12: Zero sets when an arithmetic, logic or branch result is zero.
// RULE13: Reset clears supply flags, C, DC and Z; cause bits hold the code.
// RULE14: Bit set and clear act only on read/write bits.
// RULE15: Software writes the fixed values of each register.
// RULE16: Writes to supply flags and bit 3 are ignored; bit 3 reads zero.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "acsf_cfg.svh"
module acsf_core
    import acsf_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic         clk_en_i,
    // Execution logic
    input  wire acsf_req_type req_i,
    input  wire logic         interrupt_entry_i,
    output acsf_res_type      res_o,
    output logic [7:0]        acc_o,
    // Supply detector and reset logic
    input  wire logic [1:0]   reset_cause_i,
    input  wire logic         supply_le_high_i,
    input  wire logic         supply_le_mid_i,
    input  wire logic         detector_high_option_i,
    input  wire logic         detector_mid_option_i,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    // Interrupt
    output logic              irq_o
);
    localparam int IW = `ACSF_IRQ_W;

    logic [7:0]    acc_reg, acc_next;
    logic          c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
    logic [1:0]    rc_reg, rc_next;
    logic          rc_cap_reg, rc_cap_next;
    logic [7:0]    sav_acc_reg, sav_acc_next;
    logic [2:0]    sav_fl_reg, sav_fl_next;
    logic          lv_high_reg, lv_high_next, lv_mid_reg, lv_mid_next;
    acsf_res_type  res_reg, res_next;
    logic [IW-1:0] ist_reg, ist_next, ien_reg, ien_next;
    acsf_bus_state_type bst_reg, bst_next;
    logic [31:0]   rdat_reg, rdat_next;

    logic [8:0]    sum;
    logic [4:0]    nib;
    logic [7:0]    res_v, opnd;
    logic          c_v, dc_v, upd_c, upd_dc, upd_z, write_res;
    logic          wr_psf, wr_acc, wr_clr, wr_en, req_go, lane0;
    logic [7:0]    psf_view;
    logic [IW-1:0] ev;

    assign opnd   = req_i.operand;
    assign req_go = wb_cyc_i && wb_stb_i && (bst_reg == ACSF_ST_IDLE);
    assign lane0  = wb_sel_i[0];
    assign wr_psf = req_go && wb_we_i && lane0
                    && wb_adr_i == `ACSF_OFF_PSF;
    assign wr_acc = req_go && wb_we_i && lane0
                    && wb_adr_i == `ACSF_OFF_ACC;
    assign wr_en  = req_go && wb_we_i && lane0
                    && wb_adr_i == `ACSF_OFF_IRQ_EN;
    assign wr_clr = req_go && wb_we_i && lane0
                    && wb_adr_i == `ACSF_OFF_IRQ_CLR;

    // RULE6: flag layout, RULE16 spare bit zero
    assign psf_view = {rc_reg, lv_high_reg, lv_mid_reg, 1'b0,
                       c_reg, dc_reg, z_reg};

    // ALU flags from the current operation
    always_comb begin
        sum       = 9'h000;
        nib       = 5'h00;
        res_v     = acc_reg;
        c_v       = c_reg;
        dc_v      = dc_reg;
        upd_c     = 1'b0;
        upd_dc    = 1'b0;
        upd_z     = 1'b0;
        write_res = 1'b0;
        case (req_i.op)
            // RULE10: add carry out
            ACSF_OP_ADD, ACSF_OP_ADC: begin
                sum = {1'b0, acc_reg} + {1'b0, opnd}
                      + {8'h00, (req_i.op == ACSF_OP_ADC) & c_reg};
                // RULE11: low nibble carry
                nib = {1'b0, acc_reg[3:0]} + {1'b0, opnd[3:0]}
                      + {4'h0, (req_i.op == ACSF_OP_ADC) & c_reg};
                res_v = sum[7:0];
                c_v = sum[8];
                dc_v = nib[4];
                {upd_c, upd_dc, upd_z, write_res} = 4'hF;
            end
            // RULE10: no borrow sets carry
            ACSF_OP_SUB, ACSF_OP_CMP: begin
                sum = {1'b0, acc_reg} - {1'b0, opnd};
                nib = {1'b0, acc_reg[3:0]} - {1'b0, opnd[3:0]};
                res_v = sum[7:0];
                c_v = ~sum[8];
                dc_v = ~nib[4];
                upd_c = 1'b1;
                upd_dc = req_i.op == ACSF_OP_SUB;
                upd_z = 1'b1;
                write_res = req_i.op == ACSF_OP_SUB;
            end
            ACSF_OP_AND: begin
                res_v = acc_reg & opnd;
                {upd_z, write_res} = 2'b11;
            end
            ACSF_OP_OR: begin
                res_v = acc_reg | opnd;
                {upd_z, write_res} = 2'b11;
            end
            ACSF_OP_XOR: begin
                res_v = acc_reg ^ opnd;
                {upd_z, write_res} = 2'b11;
            end
            // RULE10: rotate out into carry
            ACSF_OP_RRC: begin
                res_v = {c_reg, opnd[7:1]};
                c_v = opnd[0];
                {upd_c, write_res} = 2'b11;
            end
            ACSF_OP_RLC: begin
                res_v = {opnd[6:0], c_reg};
                c_v = opnd[7];
                {upd_c, write_res} = 2'b11;
            end
            ACSF_OP_MOVA: begin
                res_v = opnd;
                write_res = 1'b1;
            end
            // RULE12: branch result test
            ACSF_OP_ZTST: begin
                res_v = opnd;
                upd_z = 1'b1;
            end
            default: begin
                res_v = acc_reg;
            end
        endcase
    end

    // Register state next values
    always_comb begin
        acc_next     = acc_reg;
        c_next       = c_reg;
        dc_next      = dc_reg;
        z_next       = z_reg;
        sav_acc_next = sav_acc_reg;
        sav_fl_next  = sav_fl_reg;
        res_next     = '{result: res_v, result_valid: 1'b0};
        rc_next      = rc_reg;
        rc_cap_next  = 1'b1;
        // RULE7: cause code kept
        // RULE13: cause caught once after release
        if (!rc_cap_reg) begin
            rc_next = reset_cause_i;
        end
        // RULE8: high detector option flag
        lv_high_next = detector_high_option_i & supply_le_high_i;
        // RULE9: mid detector option flag
        lv_mid_next  = detector_mid_option_i & supply_le_mid_i;
        // RULE14: software bit writes, RULE16 read-only kept
        if (wr_psf) begin
            rc_next = wb_dat_i[`ACSF_BIT_RC_HI:`ACSF_BIT_RC_LO];
            c_next  = wb_dat_i[`ACSF_BIT_C];
            dc_next = wb_dat_i[`ACSF_BIT_DC];
            z_next  = wb_dat_i[`ACSF_BIT_Z];
        end
        // RULE3: bus path is a debug port, not data memory
        if (wr_acc) begin
            acc_next = wb_dat_i[7:0];
        end
        // RULE2: operation flags win over software
        if (upd_c) c_next = c_v;
        if (upd_dc) dc_next = dc_v;
        if (upd_z) z_next = (res_v == 8'h00);
        if (write_res && req_i.to_acc) begin
            // RULE1: result into accumulator
            acc_next = res_v;
        end
        res_next.result_valid = write_res;
        // RULE5: push and pop buffers
        if (req_i.op == ACSF_OP_PUSH) begin
            sav_acc_next = acc_reg;
            sav_fl_next  = {c_reg, dc_reg, z_reg};
        end
        if (req_i.op == ACSF_OP_POP) begin
            acc_next = sav_acc_reg;
            {c_next, dc_next, z_next} = sav_fl_reg;
        end
        // RULE4: interrupt entry saves nothing
        if (interrupt_entry_i) begin
            sav_acc_next = sav_acc_next;
        end
    end

    // Events: zero result, carry out, pop
    assign ev = {req_i.op == ACSF_OP_POP, upd_c & c_v,
                 upd_z & (res_v == 8'h00)};

    // Bus and interrupt next values
    always_comb begin
        bst_next  = ACSF_ST_IDLE;
        rdat_next = 32'h0000_0000;
        ien_next  = ien_reg;
        // Set wins over clear
        ist_next  = (ist_reg & ~(wr_clr ? wb_dat_i[IW-1:0] : '0)) | ev;
        if (wr_en) begin
            ien_next = wb_dat_i[IW-1:0];
        end
        if (req_go) begin
            bst_next = ACSF_ST_ACK;
            case (wb_adr_i)
                `ACSF_OFF_PSF:      rdat_next = {24'h00_0000, psf_view};
                `ACSF_OFF_ACC:      rdat_next = {24'h00_0000, acc_reg};
                `ACSF_OFF_IRQ_STAT: rdat_next = {29'h0, ist_reg};
                `ACSF_OFF_IRQ_EN:   rdat_next = {29'h0, ien_reg};
                default:            rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_reg     <= `ACSF_ACC_RST;
            c_reg       <= 1'b0;
            dc_reg      <= 1'b0;
            z_reg       <= 1'b0;
            rc_reg      <= 2'h0;
            rc_cap_reg  <= 1'b0;
            lv_high_reg <= 1'b0;
            lv_mid_reg  <= 1'b0;
            sav_acc_reg <= 8'h00;
            sav_fl_reg  <= 3'h0;
            res_reg     <= '0;
            ist_reg     <= '0;
            ien_reg     <= '0;
            bst_reg     <= ACSF_ST_IDLE;
            rdat_reg    <= 32'h0000_0000;
        end else if (clk_en_i) begin
            acc_reg     <= acc_next;
            c_reg       <= c_next;
            dc_reg      <= dc_next;
            z_reg       <= z_next;
            rc_reg      <= rc_next;
            rc_cap_reg  <= rc_cap_next;
            lv_high_reg <= lv_high_next;
            lv_mid_reg  <= lv_mid_next;
            sav_acc_reg <= sav_acc_next;
            sav_fl_reg  <= sav_fl_next;
            res_reg     <= res_next;
            ist_reg     <= ist_next;
            ien_reg     <= ien_next;
            bst_reg     <= bst_next;
            rdat_reg    <= rdat_next;
        end
    end

    assign acc_o    = acc_reg;
    assign res_o    = res_reg;
    assign wb_ack_o = bst_reg == ACSF_ST_ACK;
    assign wb_dat_o = rdat_reg;
    assign irq_o    = |(ist_reg & ien_reg);

    sequence s_push;
        clk_en_i && req_i.op == ACSF_OP_PUSH;
    endsequence
    sequence s_pop;
        clk_en_i && req_i.op == ACSF_OP_POP;
    endsequence

    AST_PUSH_POP: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!nrst_i)
        s_push ##1 (!clk_en_i || req_i.op == ACSF_OP_NONE) ##1 s_pop
        |=> acc_reg == $past(acc_reg, 2))
        else $error("Pop did not restore accumulator");
    AST_ZERO: assert property ( // RULE12
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && upd_z && req_i.op != ACSF_OP_POP
        |=> z_reg == ($past(res_v) == 8'h00))
        else $error("Zero flag wrong");
    AST_ADD_CARRY: assert property ( // RULE10
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && req_i.op == ACSF_OP_ADD
        |=> c_reg == ($past({1'b0, acc_reg} + {1'b0, opnd}) > 9'h0FF))
        else $error("Add carry wrong");
    AST_DC: assert property ( // RULE11
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && req_i.op == ACSF_OP_SUB
        |=> dc_reg == ($past(acc_reg[3:0]) >= $past(opnd[3:0])))
        else $error("Nibble borrow wrong");
    AST_SPARE: assert property ( // RULE16
        @(posedge mclk_i) disable iff (!nrst_i)
        wb_ack_o && $past(wb_adr_i) == `ACSF_OFF_PSF |-> wb_dat_o[3] == 1'b0)
        else $error("Spare bit not zero");
    AST_LV_HIGH: assert property ( // RULE8
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && !detector_high_option_i |=> !lv_high_reg)
        else $error("High supply flag without option");
    AST_LV_MID: assert property ( // RULE9
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && detector_mid_option_i && supply_le_mid_i |=> lv_mid_reg)
        else $error("Mid supply flag missed");
    AST_ACK: assert property ( // one-cycle Wishbone ack
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && req_go |=> wb_ack_o ##1 (!wb_ack_o || !$past(clk_en_i)))
        else $error("Ack not one cycle");
    AST_RC: assert property ( // RULE13
        @(posedge mclk_i) disable iff (!nrst_i)
        clk_en_i && !rc_cap_reg && !wr_psf
        |=> rc_reg == $past(reset_cause_i))
        else $error("Reset cause not caught");
endmodule
`default_nettype wire

/* tb/acsf_exec_model.sv */
// Purpose: Model of the core execution logic that issues ALU ops
// Assumes: One op per request, held over exactly one clock edge
// Notes:   An idle cycle after each op lets the result land first
`timescale 1ns/10ps
`default_nettype none
module acsf_exec_model
    import acsf_pkg::*;
(
    // Clock
    input  wire logic       mclk_i,
    // Request to the block
    output var acsf_req_type req_o
);
    initial req_o = '{ACSF_OP_NONE, 8'h00, 1'b0};

    task automatic issue(input acsf_op_type op, input logic [7:0] val);
        @(posedge mclk_i);
        req_o <= '{op, val, 1'b1};
        @(posedge mclk_i);
        req_o <= '{ACSF_OP_NONE, 8'h00, 1'b0};
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the accumulator and status flag block
// Assumes: Registered Wishbone ack, byte data in bits 7:0
// Notes:   Flags are read back over the bus after the ops under test and after push with interrupt entry, not after setup moves
`timescale 1ns/10ps
`default_nettype none
`include "acsf_cfg.svh"
module tb_top;
    import acsf_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic         mclk_i    = 1'b0;
    logic         nrst_i    = 1'b0;
    logic         int_entry = 1'b0;
    logic [1:0]   cause     = `ACSF_RC_PIN;
    logic [3:0]   supply    = 4'h0;
    logic         cyc       = 1'b0;
    logic         stb       = 1'b0;
    logic         we        = 1'b0;
    logic [7:0]   adr       = 8'h00;
    logic [31:0]  wdat      = 32'h0000_0000;
    logic [3:0]   sel       = 4'hF;
    logic [3:0]   lanes     = 4'hF;
    logic         en        = 1'b1;
    logic [31:0]  rdat;
    logic         ack;
    logic         irq;
    logic [7:0]   acc;
    acsf_req_type req;
    acsf_res_type res;
    int           failures    = 0;
    int           checks_done = 0;

    always #2.5 mclk_i = ~mclk_i;

    acsf_exec_model u_acsf_exec_model (.mclk_i(mclk_i), .req_o(req));

    // Supply order: le_high, le_mid, high option, mid option
    acsf_core u_acsf_core (
        .mclk_i                 (mclk_i),
        .nrst_i                 (nrst_i),
        .clk_en_i               (en),
        .req_i                  (req),
        .interrupt_entry_i      (int_entry),
        .res_o                  (res),
        .acc_o                  (acc),
        .reset_cause_i          (cause),
        .supply_le_high_i       (supply[3]),
        .supply_le_mid_i        (supply[2]),
        .detector_high_option_i (supply[1]),
        .detector_mid_option_i  (supply[0]),
        .wb_cyc_i               (cyc),
        .wb_stb_i               (stb),
        .wb_we_i                (we),
        .wb_adr_i               (adr),
        .wb_sel_i               (sel),
        .wb_dat_i               (wdat),
        .wb_dat_o               (rdat),
        .wb_ack_o               (ack),
        .irq_o                  (irq)
    );

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until ack is sampled, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= lanes;
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge mclk_i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t no bus answer", $time);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q & m, e);
    endtask

    task automatic op(input acsf_op_type o, input logic [7:0] v);
        u_acsf_exec_model.issue(o, v);
    endtask

    // Interrupt output follows registers; allow two falling edges to settle
    task automatic irqchk(input logic e);
        repeat (2) @(negedge mclk_i);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    // Result and accumulator stand from the op edge to the next
    task automatic reschk(input logic [7:0] r, input logic v);
        @(negedge mclk_i);
        chk({23'h0, res}, {23'h0, r, v});
        chk({24'h0, acc}, {24'h0, r});
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C0);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_0000);
        rd(8'h84, ALL, 32'h0000_0000);
        op(ACSF_OP_MOVA, 8'h0F);
        op(ACSF_OP_ADD, 8'h01);
        reschk(8'h10, 1'b1);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_0010);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C2);
        op(ACSF_OP_ADD, 8'hF0);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C5);
        op(ACSF_OP_MOVA, 8'h10);
        op(ACSF_OP_SUB, 8'h01);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C4);
        op(ACSF_OP_SUB, 8'h10);
        reschk(8'hFF, 1'b1);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_00FF);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C2);
        op(ACSF_OP_CMP, 8'hFF);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C7);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_00FF);
        op(ACSF_OP_MOVA, 8'h00);
        op(ACSF_OP_RLC, 8'h00);
        rd(`ACSF_OFF_PSF, 32'h0000_0004, 32'h0000_0000);
        op(ACSF_OP_MOVA, 8'h01);
        // Rotation works on its operand, so the low one shifts out
        op(ACSF_OP_RRC, 8'h01);
        rd(`ACSF_OFF_PSF, 32'h0000_0004, 32'h0000_0004);
        op(ACSF_OP_ADC, 8'h0F);
        reschk(8'h10, 1'b1);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C2);
        op(ACSF_OP_AND, 8'h01);
        rd(`ACSF_OFF_PSF, 32'h0000_0001, 32'h0000_0001);
        op(ACSF_OP_OR, 8'hA5);
        rd(`ACSF_OFF_PSF, 32'h0000_0001, 32'h0000_0000);
        op(ACSF_OP_XOR, 8'hA5);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_0000);
        op(ACSF_OP_ZTST, 8'h01);
        rd(`ACSF_OFF_PSF, 32'h0000_0001, 32'h0000_0000);
        wr(`ACSF_OFF_IRQ_CLR, 32'h0000_0007);
        wr(`ACSF_OFF_IRQ_EN, 32'h0000_0001);
        rd(`ACSF_OFF_IRQ_STAT, ALL, 32'h0000_0000);
        irqchk(1'b0);
        op(ACSF_OP_MOVA, 8'h5A);
        op(ACSF_OP_ADD, 8'h00);
        op(ACSF_OP_PUSH, 8'h00);
        @(posedge mclk_i);
        int_entry <= 1'b1;
        @(posedge mclk_i);
        int_entry <= 1'b0;
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_005A);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C0);
        op(ACSF_OP_ADD, 8'hA6);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C7);
        rd(`ACSF_OFF_IRQ_STAT, ALL, 32'h0000_0003);
        irqchk(1'b1);
        wr(`ACSF_OFF_IRQ_EN, 32'h0000_0000);
        irqchk(1'b0);
        wr(`ACSF_OFF_IRQ_CLR, 32'h0000_0003);
        rd(`ACSF_OFF_IRQ_STAT, ALL, 32'h0000_0000);
        wr(`ACSF_OFF_IRQ_EN, 32'h0000_0004);
        op(ACSF_OP_POP, 8'h00);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_005A);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C0);
        // Enable low: the op must leave the accumulator alone
        en <= 1'b0;
        op(ACSF_OP_MOVA, 8'h33);
        en <= 1'b1;
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_005A);
        op(ACSF_OP_PUSH, 8'h00);
        op(ACSF_OP_POP, 8'h00);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_005A);
        rd(`ACSF_OFF_IRQ_STAT, ALL, 32'h0000_0004);
        irqchk(1'b1);
        wr(`ACSF_OFF_IRQ_CLR, 32'h0000_0004);
        irqchk(1'b0);
        // A write without lane 0 is dropped
        lanes = 4'hE;
        wr(`ACSF_OFF_ACC, 32'h0000_0077);
        lanes = 4'hF;
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_005A);
        wr(`ACSF_OFF_ACC, 32'h0000_0077);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_0077);
        // Read-only and spare bits must not take the written ones
        wr(`ACSF_OFF_PSF, 32'h0000_00FF);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_00C7);
        wr(`ACSF_OFF_PSF, 32'h0000_0080);
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_0080);
        supply <= 4'hE;
        rd(`ACSF_OFF_PSF, 32'h0000_0030, 32'h0000_0020);
        supply <= 4'hD;
        rd(`ACSF_OFF_PSF, 32'h0000_0030, 32'h0000_0010);
        supply <= 4'h3;
        rd(`ACSF_OFF_PSF, 32'h0000_0030, 32'h0000_0000);
        // Second reset with a watchdog cause
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        cause  <= `ACSF_RC_WDT;
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(`ACSF_OFF_PSF, ALL, 32'h0000_0000);
        rd(`ACSF_OFF_ACC, ALL, 32'h0000_0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
